// ### hw/wwd_top.sv
// window watchdog instance with apb register slave
`timescale 1ns/1ns
`default_nettype none

// Operation
// - 25-bit time base, closed then open window
// - counts low-frequency clock through programmable divider
// - eight selectable periods set total count
// - optional suspend while in low power
// - watchdog mode or interval timer mode
// - first instance violation requests boot reset
// - second instance violation requests system reset
// - one or two independent instances exist
// - watchdog counts up from zero to period
// - closed window first, then open window
// - restart in closed window is a violation
// - no restart by period end is violation
// - zero closed window allows restart anytime
// - interval mode interrupts on expiry, no reset
// - interval mode interrupts on wrong password
// - interval interrupts are maskable
// - failure drives violation to system controller
// - restart key resets count, other values violate
// - keyed 32-bit writes, password reads zero
// - first keyed static write enables, then locked
// - divider selects one to eight
module wwd_top
    import wwd_pkg::*;
#(
    parameter int INST = 0 // 0 is instance a, 1 is instance b
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system state
    input wire logic low_power_mode,
    // toward system controller and processor
    output logic violation,
    output logic boot_reset_req,
    output logic system_reset_req,
    output logic irq
);

    if (INST < 0 || INST > 1) begin : g_bad_inst
        $error("instance position must be 0 or 1");
    end

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic en_reg;              // enabled by first keyed write
    logic [2:0] div_reg;       // divider_field
    logic [2:0] per_reg;       // period select
    logic [2:0] win0_reg;      // closed window choice 0
    logic [2:0] win1_reg;      // closed window choice 1
    logic mode_reg;            // 1 is interval timer
    logic stop_reg;            // suspend in low power
    logic winsel_reg;          // active window choice
    logic [CNT_W-1:0] cnt_reg; // time base
    logic viol_reg;            // sticky violation
    logic iflag_reg;           // sticky interval interrupt
    logic imask_reg;           // 1 lets the interrupt out
    logic [31:0] rdata_reg;    // read data captured at setup

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire full_word = (pstrb == 4'hf);
    wire [7:0] key = pwdata[F_KEY +: 8];
    wire sel_ctl0 = (paddr == OFF_CTL0);
    wire sel_ctl1 = (paddr == OFF_CTL1);
    wire sel_rst = (paddr == OFF_RST);
    wire sel_stat = (paddr == OFF_STAT);
    wire sel_imask = (paddr == OFF_IMASK);
    wire sel_iflag = (paddr == OFF_IFLAG);
    wire mapped = sel_ctl0 || sel_ctl1 || sel_rst || sel_stat
        || sel_imask || sel_iflag;

    // zero wait states, error only for unmapped addresses
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_reg;

    // -----------------------------------------------------------------
    // write qualification
    // -----------------------------------------------------------------
    wire wr_ctl0 = wr && sel_ctl0;
    wire wr_ctl1 = wr && sel_ctl1;
    wire wr_rst = wr && sel_rst;
    wire ok_ctl0 = full_word && (key == KEY_CTL0);
    wire ok_ctl1 = full_word && (key == KEY_CTL1);
    wire ok_rst = full_word && (pwdata == RESTART_KEY);

    wire key_err = (wr_ctl0 && !ok_ctl0) || (wr_ctl1 && !ok_ctl1);
    // enable on first keyed static write
    wire load_ctl0 = wr_ctl0 && ok_ctl0 && !en_reg;
    wire lock_err = wr_ctl0 && ok_ctl0 && en_reg;
    // anything but the restart key faults
    wire rst_val_err = wr_rst && !ok_rst;

    // -----------------------------------------------------------------
    // window arithmetic
    // -----------------------------------------------------------------
    wire wd_mode = !mode_reg;
    wire [2:0] win_sel = winsel_reg ? win1_reg : win0_reg;
    wire [4:0] psh = 5'(per_shift(per_reg));

    // last count of the chosen period
    wire [CNT_W:0] per_count = (CNT_W+1)'(1) << psh;
    wire [CNT_W-1:0] per_last = CNT_W'(per_count - (CNT_W+1)'(1));

    // closed part is the leading sixteenths
    // periods are at least 2^6 so the shift stays exact
    wire [CNT_W-1:0] closed_cnt =
        CNT_W'({21'h0, win_16ths(win_sel)} << (psh - 5'd4));

    // zero sixteenths leaves no closed part
    wire in_closed = cnt_reg < closed_cnt;

    wire closed_err = wr_rst && ok_rst && en_reg && wd_mode
        && in_closed;
    wire good_restart = wr_rst && ok_rst && en_reg
        && !(wd_mode && in_closed);

    // -----------------------------------------------------------------
    // time base
    // -----------------------------------------------------------------
    // suspend only when the option asks for it
    wire running = en_reg && !(stop_reg && low_power_mode);
    wire tick;

    // divider_field gives divide by one to eight
    wwd_tick_div u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(!en_reg || good_restart),
        .enable(running),
        .div_sel(div_reg),
        .tick(tick)
    );

    // end of open window without restart
    wire expire = running && tick && (cnt_reg == per_last);

    // -----------------------------------------------------------------
    // event routing
    // -----------------------------------------------------------------
    // watchdog faults become a violation
    wire wd_fault = wd_mode && (key_err || lock_err || rst_val_err
        || closed_err || expire);
    // a bad password interrupts as well
    wire int_event = mode_reg && (expire || key_err || lock_err);
    wire iflag_clr = wr && sel_iflag && pwdata[0];

    // once set, only reset removes it
    wire viol_next = viol_reg || wd_fault;
    // set wins over a clear in the same cycle
    wire iflag_next = int_event || (iflag_reg && !iflag_clr);

    // count up from zero, wrap after last
    wire [CNT_W-1:0] cnt_next =
        (!en_reg || good_restart || expire) ? '0
        : (running && tick) ? cnt_reg + CNT_W'(1)
        : cnt_reg;

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    // password byte always reads as zero
    wire [31:0] rd_ctl0 = {14'h0, stop_reg, mode_reg,
        1'b0, win1_reg, 1'b0, win0_reg,
        1'b0, per_reg, 1'b0, div_reg};
    wire [31:0] rd_mux =
        sel_ctl0 ? rd_ctl0
        : sel_ctl1 ? {31'h0, winsel_reg}
        : sel_stat ? {30'h0, viol_reg, running}
        : sel_imask ? {31'h0, imask_reg}
        : sel_iflag ? {31'h0, iflag_reg}
        : 32'h0000_0000;

    // -----------------------------------------------------------------
    // static configuration
    // -----------------------------------------------------------------
    // mode, divider, period and both window sizes fixed at enable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            en_reg <= 1'b0;
            div_reg <= DIV_RESET;
            per_reg <= 3'h0;
            win0_reg <= 3'h0;
            win1_reg <= 3'h0;
            mode_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else if (load_ctl0) begin
            en_reg <= 1'b1;
            div_reg <= pwdata[F_DIV +: 3];
            per_reg <= pwdata[F_PER +: 3];
            win0_reg <= pwdata[F_WIN0 +: 3];
            win1_reg <= pwdata[F_WIN1 +: 3];
            mode_reg <= pwdata[F_MODE];
            stop_reg <= pwdata[F_STOP];
        end
    end

    // -----------------------------------------------------------------
    // dynamic configuration and mask
    // -----------------------------------------------------------------
    // window choice may change while running
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            winsel_reg <= 1'b0;
            imask_reg <= 1'b0;
        end else begin
            if (wr_ctl1 && ok_ctl1) begin
                winsel_reg <= pwdata[0];
            end
            if (wr && sel_imask) begin
                imask_reg <= pwdata[0];
            end
        end
    end

    // -----------------------------------------------------------------
    // counter, flags, read data
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            viol_reg <= 1'b0;
            iflag_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            cnt_reg <= cnt_next;
            viol_reg <= viol_next;
            iflag_reg <= iflag_next;
            if (setup && !pwrite) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign violation = viol_reg;
    // instance a asks for a boot reset
    assign boot_reset_req = viol_reg && (INST == 0);
    // instance b asks for a system reset
    assign system_reset_req = viol_reg && (INST == 1);
    assign irq = iflag_reg && imask_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // cycles since the last tick or divider clear; only the checks
    // read it, and it wraps harmlessly while the count is suspended
    logic [12:0] gap_reg;
    // expected spacing of divided ticks for the current divider_field
    wire [12:0] gap_want = 13'((32'(div_reg) + 32'd1) * LF_CYC - 32'd1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_reg <= 13'h0;
        end else if (tick || !en_reg || good_restart) begin
            gap_reg <= 13'h0;
        end else begin
            gap_reg <= gap_reg + 13'h1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence seq_good_restart;
        wr_rst && ok_rst && en_reg && !in_closed;
    endsequence

    sequence seq_last_tick;
        running && tick && cnt_reg == per_last;
    endsequence

    a_viol_hold: assert property (
        viol_reg |=> viol_reg [*8])
        else $error("violation dropped before reset");

    a_bad_key: assert property (
        wd_mode && wr && sel_ctl1 && key != KEY_CTL1 |=> violation)
        else $error("bad password not flagged");

    a_restart_val: assert property (
        wd_mode && wr_rst && pwdata != RESTART_KEY |=> violation)
        else $error("wrong restart value not flagged");

    a_restart_zero: assert property (
        seq_good_restart |=> cnt_reg == '0)
        else $error("restart did not clear count");

    a_early_restart: assert property (
        en_reg && wd_mode && wr_rst && ok_rst && cnt_reg == '0
        && closed_cnt != '0 |=> violation)
        else $error("closed window restart missed");

    a_expire_viol: assert property (
        (wd_mode and seq_last_tick) |=> violation && cnt_reg == '0)
        else $error("expiry not flagged");

    a_interval_irq: assert property (
        ((mode_reg && !viol_reg) and seq_last_tick)
        |=> iflag_reg && !violation)
        else $error("interval expiry wrong");

    a_lock_ctl0: assert property (
        en_reg && wr_ctl0 |=> (violation || iflag_reg)
        && $stable(per_reg))
        else $error("locked static write accepted");

    a_mask_gate: assert property (
        !imask_reg && iflag_reg && !iflag_clr |=> iflag_reg)
        else $error("masked interrupt not kept pending");

    a_reset_route: assert property (
        violation |-> (boot_reset_req != system_reset_req))
        else $error("reset request routing wrong");

    a_tick_space: assert property (
        tick && !stop_reg |-> gap_reg == gap_want)
        else $error("divided tick spacing wrong");

endmodule : wwd_top

`default_nettype wire

// ### include/wwd_pkg.sv
// shared constants for the window watchdog block
package wwd_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000; // system clock rate
    localparam int unsigned LF_HZ = 32_768;      // low_freq_clock rate
    // system cycles per low-frequency tick, rounded down
    localparam int unsigned LF_CYC = CLK_HZ / LF_HZ;
    localparam int CNT_W = 25;                   // time base width

    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFF_CTL0 = 8'h00; // static_config_register
    localparam logic [7:0] OFF_CTL1 = 8'h04; // dynamic_config_register
    localparam logic [7:0] OFF_RST = 8'h08;  // counter_restart_register
    localparam logic [7:0] OFF_STAT = 8'h0c; // run and violation status
    localparam logic [7:0] OFF_IMASK = 8'h10; // interrupt mask
    localparam logic [7:0] OFF_IFLAG = 8'h14; // flag, write one clears

    // -----------------------------------------------------------------
    // keys and field layout
    // -----------------------------------------------------------------
    localparam logic [7:0] KEY_CTL0 = 8'hc9;
    localparam logic [7:0] KEY_CTL1 = 8'hbe;
    localparam logic [31:0] RESTART_KEY = 32'h0000_00a7;
    localparam int F_DIV = 0;    // divider_field [2:0]
    localparam int F_PER = 4;    // period select [6:4]
    localparam int F_WIN0 = 8;   // closed window 0 [10:8]
    localparam int F_WIN1 = 12;  // closed window 1 [14:12]
    localparam int F_MODE = 16;  // 1 selects interval timer
    localparam int F_STOP = 17;  // 1 suspends in low power
    localparam int F_KEY = 24;   // password byte [31:24]
    localparam logic [2:0] DIV_RESET = 3'h3; // divide by four

    // -----------------------------------------------------------------
    // period and window tables
    // -----------------------------------------------------------------
    // log2 of the total count for each period select
    function automatic int unsigned per_shift(input logic [2:0] sel);
        unique case (sel)
            3'h0: per_shift = 25;
            3'h1: per_shift = 21;
            3'h2: per_shift = 18;
            3'h3: per_shift = 15;
            3'h4: per_shift = 12;
            3'h5: per_shift = 10;
            3'h6: per_shift = 8;
            3'h7: per_shift = 6;
        endcase
    endfunction : per_shift

    // closed part of the period in sixteenths
    function automatic logic [3:0] win_16ths(input logic [2:0] sel);
        unique case (sel)
            3'h0: win_16ths = 4'h0;
            3'h1: win_16ths = 4'h2;
            3'h2: win_16ths = 4'h3;
            3'h3: win_16ths = 4'h4;
            3'h4: win_16ths = 4'h8;
            3'h5: win_16ths = 4'hc;
            3'h6: win_16ths = 4'hd;
            3'h7: win_16ths = 4'he;
        endcase
    endfunction : win_16ths

endpackage : wwd_pkg

// ### hw/wwd_tick_div.sv
// low-frequency tick source and programmable divider
`timescale 1ns/1ns
`default_nettype none

module wwd_tick_div
    import wwd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic enable,
    input wire logic [2:0] div_sel,
    // output
    output logic tick
);

    localparam logic [9:0] LF_LAST = 10'(LF_CYC - 1);

    // elaboration refuses rates the ten-bit prescaler cannot serve
    if (LF_CYC < 2 || LF_CYC > 1024) begin : g_bad_rate
        $error("system clock too slow or fast for tick");
    end

    logic [9:0] pre_reg; // system cycles within one lf period
    logic [2:0] div_reg; // lf ticks within one divided tick
    logic pre_wrap;
    logic div_wrap;

    // -----------------------------------------------------------------
    // decoding
    // -----------------------------------------------------------------
    assign pre_wrap = enable && (pre_reg == LF_LAST);
    assign div_wrap = (div_reg == div_sel);
    assign tick = pre_wrap && div_wrap;

    // -----------------------------------------------------------------
    // counters
    // -----------------------------------------------------------------
    // clear restarts both stages so the first tick is a full period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_reg <= 10'h000;
            div_reg <= 3'h0;
        end else if (clear) begin
            pre_reg <= 10'h000;
            div_reg <= 3'h0;
        end else if (pre_wrap) begin
            pre_reg <= 10'h000;
            div_reg <= div_wrap ? 3'h0 : div_reg + 3'h1;
        end else if (enable) begin
            pre_reg <= pre_reg + 10'h001;
        end
    end

endmodule : wwd_tick_div

`default_nettype wire

// ### tb/wwd_system_controller_model.sv
// system controller model turning watchdog requests into resets
`timescale 1ns/1ns
`default_nettype none

module wwd_ctrl_model (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic por,
    // high for a slow answer
    input wire logic slow,
    // requests from the watchdog instances
    input wire logic boot_reset_req,
    input wire logic system_reset_req,
    // reset back to the device, and tallies
    output logic dev_rst,
    output int boot_cnt,
    output int sys_cnt
);
    int dly;  // cycles a request has waited
    int hold; // reset cycles still to issue

    // ----------------------------------------------------------
    // request to reset pulse
    // ----------------------------------------------------------
    // controller issues the reset
    always @(posedge clk_sys or posedge por) begin
        if (por) begin
            dly <= 0;
            hold <= 0;
            dev_rst <= 1'b0;
            boot_cnt <= 0;
            sys_cnt <= 0;
        end else if (hold != 0) begin
            // pulse runs out, then releases
            hold <= hold - 1;
            dev_rst <= hold > 1;
        end else if (boot_reset_req || system_reset_req) begin
            // a slow answer leaves the request standing longer
            if (dly >= (slow ? 40 : 4)) begin
                dly <= 0;
                hold <= 4;
                dev_rst <= 1'b1;
                boot_cnt <= boot_cnt + int'(boot_reset_req);
                sys_cnt <= sys_cnt + int'(system_reset_req);
            end else begin
                dly <= dly + 1;
            end
        end else begin
            dly <= 0;
        end
    end
endmodule : wwd_ctrl_model

`default_nettype wire

// ### tb/tb_window_watchdog_timer.sv
// self-checking bench for two watchdog instances
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end

module tb_window_watchdog_timer
    import wwd_pkg::*;
;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic clk_sys = 1'b0;
    logic por = 1'b1; // power-on reset
    logic slow = 1'b0;
    logic psel_a = 1'b0;
    logic psel_b = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic low_power_mode = 1'b0;
    wire logic dev_rst;
    wire logic rst = por | dev_rst;
    logic [31:0] prdata_a, prdata_b, rdat;
    logic pready_a, pready_b, pslverr_a, pslverr_b, rerr, ok;
    logic viol_a, viol_b, boot_a, boot_b, sys_a, sys_b, irq_a, irq_b;
    int boot_cnt, sys_cnt, fails = 0, checked = 0, cyc = 0;
    logic [31:0] rnd = 32'hbcbe38e6; // lfsr state
    time t_a, t_b;
    longint el;

    wwd_top #(.INST(0)) i_dut (.clk_sys, .rst, .psel(psel_a), .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_a),
        .pready(pready_a), .pslverr(pslverr_a), .low_power_mode,
        .violation(viol_a), .boot_reset_req(boot_a),
        .system_reset_req(sys_a), .irq(irq_a));
    wwd_top #(.INST(1)) i_dut_b (.clk_sys, .rst, .psel(psel_b), .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_b),
        .pready(pready_b), .pslverr(pslverr_b), .low_power_mode,
        .violation(viol_b), .boot_reset_req(boot_b),
        .system_reset_req(sys_b), .irq(irq_b));
    wwd_ctrl_model i_ctl (.clk_sys, .por, .slow,
        .boot_reset_req(boot_a | boot_b),
        .system_reset_req(sys_a | sys_b), .dev_rst, .boot_cnt, .sys_cnt);

    always #20 clk_sys = ~clk_sys;

    // cycle ceiling cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 75000) begin
            fails++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // keyed static word, divider field left at zero
    function automatic logic [31:0] cfg(input logic [2:0] per, w0,
        input logic md, sp);
        return (32'(KEY_CTL0) << F_KEY) | (32'(per) << F_PER) |
            (32'(w0) << F_WIN0) | (32'(md) << F_MODE) | (32'(sp) << F_STOP);
    endfunction : cfg

    function automatic logic pick(input int s);
        return s == 0 ? viol_a : s == 1 ? viol_b : s == 2 ? irq_b :
            s == 3 ? dev_rst : !dev_rst;
    endfunction : pick

    // one apb transfer; b picks instance b
    task automatic apb(input logic b, wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] st);
        @(posedge clk_sys);
        psel_a <= !b;
        psel_b <= b;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no local limit: only the bench ceiling ends a stuck wait
        while ((b ? pready_b : pready_a) !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdat = b ? prdata_b : prdata_a;
        rerr = b ? pslverr_b : pslverr_a;
        psel_a <= 1'b0;
        psel_b <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for a design output to rise
    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : wait_hi

    task automatic wait_rst();
        wait_hi(3, 100);
        wait_hi(4, 20);
    endtask : wait_rst

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        por <= 1'b0;
        apb(0, 0, OFF_CTL0, 0, 4'hf);
        `CHK("ctl0", 32'(DIV_RESET), rdat)
        apb(0, 0, OFF_STAT, 0, 4'hf);
        `CHK("stat", 32'h0, rdat)
        apb(0, 0, 8'h18, 0, 4'hf);
        `CHK("unmapped", 1'b1, rerr)
        $display("test reset values done");
        // enable, restart at once with no closed part, then locked write
        apb(0, 1, OFF_CTL0, cfg(7, 0, 0, 0), 4'hf);
        apb(0, 0, OFF_STAT, 0, 4'hf);
        `CHK("running", 32'h1, rdat)
        apb(0, 0, OFF_CTL0, 0, 4'hf);
        `CHK("key byte", cfg(7, 0, 0, 0) & 32'h00ff_ffff, rdat)
        apb(0, 1, OFF_RST, RESTART_KEY, 4'hf);
        repeat (2) @(posedge clk_sys);
        `CHK("open restart", 1'b0, viol_a)
        apb(0, 1, OFF_CTL0, cfg(7, 0, 0, 0), 4'hf);
        wait_hi(0, 4);
        `CHK("locked", 1'b1, boot_a)
        `CHK("sys a", 1'b0, sys_a)
        wait_rst();
        `CHK("boots", 1, boot_cnt)
        $display("test lock done");
        // restart in closed window, controller slow to answer
        slow <= 1'b1;
        apb(1, 1, OFF_CTL0, cfg(7, 7, 0, 0), 4'hf);
        apb(1, 1, OFF_RST, RESTART_KEY, 4'hf);
        wait_hi(1, 4);
        `CHK("closed", 1'b1, sys_b)
        repeat (30) @(posedge clk_sys);
        `CHK("held", 1'b1, viol_b)
        `CHK("boot b", 1'b0, boot_b)
        wait_rst();
        `CHK("sysrsts", 1, sys_cnt)
        slow <= 1'b0;
        $display("test closed window done");
        // a divides by two, b restarts once its closed part is over
        apb(0, 1, OFF_CTL0, cfg(7, 1, 0, 0) | (32'h1 << F_DIV), 4'hf);
        apb(1, 1, OFF_CTL0, cfg(7, 1, 0, 0), 4'hf);
        repeat (10 * LF_CYC) @(posedge clk_sys);
        apb(1, 1, OFF_RST, RESTART_KEY, 4'hf);
        apb(0, 1, OFF_RST, RESTART_KEY, 4'hf);
        wait_hi(0, 4);
        `CHK("open b", 1'b0, viol_b)
        `CHK("div two", 1'b1, viol_a)
        wait_rst();
        $display("test divider done");
        // random bad restart values, keys and strobes on both
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            apb(k[0], 1, OFF_CTL0, cfg(7, 0, 0, 0), 4'hf);
            case (k % 3)
                0: apb(k[0], 1, OFF_RST, rnd | 32'h100, 4'hf);
                1: apb(k[0], 1, OFF_CTL1,
                    {KEY_CTL1 ^ (rnd[31:24] | 8'h01), rnd[23:0]}, 4'hf);
                default: apb(k[0], 1, OFF_CTL1, {KEY_CTL1, 24'h0},
                    rnd[3:0] & 4'h7);
            endcase
            wait_hi(k[0], 4);
            `CHK("bad", 1'b1, k[0] ? viol_b : viol_a)
            wait_rst();
        end
        $display("test bad access done");
        // interval b and suspended a share the low-power input
        apb(1, 1, OFF_IMASK, 32'h1, 4'hf);
        low_power_mode <= 1'b1;
        apb(0, 1, OFF_IMASK, 32'h1, 4'hf);
        apb(0, 1, OFF_CTL0, cfg(7, 0, 0, 1), 4'hf);
        t_a = $time;
        apb(1, 1, OFF_CTL0, cfg(7, 0, 1, 0), 4'hf);
        t_b = $time;
        repeat (8 * LF_CYC - 3) @(posedge clk_sys);
        low_power_mode <= 1'b0;
        wait_hi(2, 64 * LF_CYC);
        el = ($time - t_b) / 40;
        ok = el >= 64 * LF_CYC - 1 && el <= 64 * LF_CYC + 3;
        `CHK("period", 1'b1, ok)
        `CHK("irq reset", 1'b0, sys_b)
        `CHK("suspend", 1'b0, viol_a)
        apb(1, 1, OFF_IMASK, 32'h0, 4'hf);
        #1;
        `CHK("masked", 1'b0, irq_b)
        apb(1, 1, OFF_IFLAG, 32'h1, 4'hf);
        apb(1, 1, OFF_IMASK, 32'h1, 4'hf);
        #1;
        `CHK("cleared", 1'b0, irq_b)
        apb(1, 1, OFF_CTL1, 32'h0, 4'hf);
        wait_hi(2, 4);
        `CHK("pw irq", 1'b1, irq_b)
        `CHK("viol b", 1'b0, viol_b)
        wait_hi(0, 12 * LF_CYC);
        el = ($time - t_a) / 40;
        ok = el >= 71 * LF_CYC - 5 && el <= 73 * LF_CYC + 5;
        `CHK("expiry", 1'b1, ok)
        `CHK("wd irq", 1'b0, irq_a)
        wait_rst();
        $display("test expiry done");
        wrap_up();
    end
endmodule : tb_window_watchdog_timer

`default_nettype wire
